// [common/hub_strap_map.svh]
`ifndef HUB_STRAP_MAP_SVH
`define HUB_STRAP_MAP_SVH

// register byte offsets
`define CTRL_OFS 4'h0
`define STATUS_OFS 4'h4
`define IND_OFS 4'h8

// control register fields and reset value
`define CTRL_HS_BIT 0
`define CTRL_CFGD_BIT 1
`define CTRL_SUSP_BIT 2
`define CTRL_W 3
`define CTRL_RST 3'h0

// status register fields
`define ST_CFG_HI_BIT 0
`define ST_CFG_LO_BIT 1
`define ST_METHOD_LSB 2
`define ST_SELF_PWR_BIT 4
`define ST_FIX_LSB 5
`define ST_MASK_LSB 8
`define ST_VALID_BIT 12
`define ST_SPD_LOW_BIT 13
`define ST_ACT_LOW_BIT 14
`define ST_REF_ACT_BIT 15
`define ST_SHORT_RST_BIT 16
`define ST_FSM_LSB 17

// indicator register fields
`define IND_SPD_BIT 0
`define IND_ACT_BIT 1
`define IND_OE_BIT 2

// timing
`define CLK_PERIOD_NS 50
`define RESET_MIN_NS 1000
`define RESET_MIN_CYC \
  ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REF_OSC_KHZ 24000
`define REF_WIN_CYC 16

// pin synchroniser lanes
`define SY_RST_N 0
`define SY_SPD 1
`define SY_ACT 2
`define SY_CFG_LO 3
`define SY_FIX_MSB 4
`define SY_REF 5
`define SY_W 6
// reset pin lane idles high so no false release follows reset
`define SY_IDLE 6'h01

`endif

// [common/hub_strap_pkg.sv]
package hub_strap_pkg;

  typedef enum logic [1:0] {
    ST_HELD  = 2'b00,
    ST_LATCH = 2'b01,
    ST_RUN   = 2'b11
  } rst_state_t;

  typedef enum logic [1:0] {
    CFG_METHOD_0 = 2'b00,
    CFG_METHOD_1 = 2'b01,
    CFG_METHOD_2 = 2'b10,
    CFG_METHOD_3 = 2'b11
  } cfg_method_t;

  typedef enum logic {
    PWR_BUS_ONLY = 1'b0,
    PWR_LOCAL    = 1'b1
  } power_src_t;

  typedef enum logic [1:0] {
    FIX_NONE = 2'b00,
    FIX_P1   = 2'b01,
    FIX_P12  = 2'b10,
    FIX_P123 = 2'b11
  } fixed_code_t;

  // one bit per downstream port, set where the port is non-removable
  function automatic logic [3:0] fixed_port_mask(input fixed_code_t c);
    unique case (c)
      FIX_NONE: fixed_port_mask = 4'h0;
      FIX_P1:   fixed_port_mask = 4'h1;
      FIX_P12:  fixed_port_mask = 4'h3;
      FIX_P123: fixed_port_mask = 4'h7;
    endcase
  endfunction

endpackage

// [common/strap_if.sv]
`timescale 1ns/10ps
interface strap_if;
  import hub_strap_pkg::*;
  logic pin_cfg_hi;
  logic pin_cfg_lo;
  logic pin_shared;
  logic pin_fix_msb;
  logic latch;
  logic hold;
  logic valid;
  logic cfg_hi;
  cfg_method_t method;
  power_src_t power_src;
  fixed_code_t fixed_code;

  modport sampler (
    input pin_cfg_hi, pin_cfg_lo, pin_shared, pin_fix_msb, latch, hold,
    output valid, cfg_hi, method, power_src, fixed_code
  );
  modport user (
    output pin_cfg_hi, pin_cfg_lo, pin_shared, pin_fix_msb, latch, hold,
    input valid, cfg_hi, method, power_src, fixed_code
  );
endinterface

// [dv/board_model.sv]
`timescale 1ns/10ps
module board_model (
  input wire logic clk_i,
  input wire logic strap_hi_i,
  input wire logic strap_act_i,
  input wire logic spd_i,
  input wire logic spd_oe_i,
  input wire logic act_i,
  input wire logic act_oe_i,
  output logic spd_pin_o,
  output logic act_pin_o,
  output logic ref_osc_o
);
  logic ref_q = 1'b0;
  // strap resistor sets the level whenever the hub releases the pin
  assign spd_pin_o = spd_oe_i ? spd_i : strap_hi_i;
  assign act_pin_o = act_oe_i ? act_i : strap_act_i;
  always_ff @(posedge clk_i) begin
    ref_q <= ~ref_q;
  end
  assign ref_osc_o = ref_q;
endmodule

// [dv/hub_strap_sva.sv]
`timescale 1ns/10ps
module hub_strap_sva #(
  parameter int unsigned REF_WIN = 16
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ext_reset_n_i,
  input wire logic upstream_speed_indicator_o,
  input wire logic upstream_speed_indicator_oe_o,
  input wire logic activity_indicator_o,
  input wire logic activity_indicator_oe_o,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o
);
  logic oe;
  logic tk;
  assign oe = upstream_speed_indicator_oe_o;
  assign tk = avs_write_i && !avs_waitrequest_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  a_oe_pair: assert property (oe == activity_indicator_oe_o)
    else $error("indicator enables differ");
  a_oe_after_rst: assert property ($fell(reset_i) |-> !oe)
    else $error("enable high right after reset");
  a_idle_dark: assert property (!oe |->
    !upstream_speed_indicator_o && !activity_indicator_o)
    else $error("indicator level while released");
  a_held_off: assert property (!ext_reset_n_i [*8] |-> !oe)
    else $error("pins driven while pin reset held");
  a_rel_drive: assert property (!ext_reset_n_i [*8] ##1
    ext_reset_n_i [*5] |-> oe)
    else $error("pins not driven after release");
  a_spd_cause: assert property (oe && $past(oe, 2) &&
    $changed(upstream_speed_indicator_o) |->
    $past(tk) || $past(tk, 2))
    else $error("speed indicator moved without control write");
  a_act_cause: assert property (oe && $past(oe, 2) &&
    $changed(activity_indicator_o) |->
    $past(tk) || $past(tk, 2))
    else $error("activity indicator moved without control write");
  a_wait_once: assert property ($rose(avs_read_i || avs_write_i) |->
    avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("waitrequest not exactly one cycle");
endmodule
bind hub_strap_top hub_strap_sva #(.REF_WIN(REF_WIN)) u_sva (.clk_i,
  .reset_i, .ext_reset_n_i, .upstream_speed_indicator_o,
  .upstream_speed_indicator_oe_o, .activity_indicator_o,
  .activity_indicator_oe_o, .avs_read_i, .avs_write_i, .avs_waitrequest_o);

// [dv/test_hub_strap_and_status_pins.sv]
`timescale 1ns/10ps
`include "hub_strap_map.svh"
module test_hub_strap_and_status_pins;
  logic clk_i = 0, reset_i = 1, ext_n = 1, hi = 0, lo = 0, f0 = 0, f1 = 0;
  logic rd = 0, wr = 0, wreq, spd_pin, act_pin, ref_pin;
  logic spd_o, spd_oe, act_o, act_oe, xo;
  logic [3:0] adr = 4'h0, be = 4'hf;
  logic [31:0] wd = 32'h0, rdat, q, e;
  int n_mismatch = 0, checks_done = 0;
  always #25 clk_i = ~clk_i;
  hub_strap_top #(.REF_WIN(4)) DUT (.clk_i, .reset_i, .ext_reset_n_i(ext_n),
    .upstream_speed_indicator_i(spd_pin), .upstream_speed_indicator_o(spd_o),
    .upstream_speed_indicator_oe_o(spd_oe), .activity_indicator_i(act_pin),
    .activity_indicator_o(act_o), .activity_indicator_oe_o(act_oe),
    .config_method_select_lo_i(lo), .fixed_port_strap_msb_i(f1),
    .ref_osc_in_i(ref_pin), .ref_osc_out_o(xo), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq));
  board_model BM (.clk_i, .strap_hi_i(hi), .strap_act_i(f0), .spd_i(spd_o),
    .spd_oe_i(spd_oe), .act_i(act_o), .act_oe_i(act_oe),
    .spd_pin_o(spd_pin), .act_pin_o(act_pin), .ref_osc_o(ref_pin));
  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 20) begin
      n_mismatch++;
      wrap_up();
    end
  endtask
  // one word per request, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [3:0] b);
    int n;
    n = 0;
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    be <= b;
    do begin
      @(posedge clk_i);
      n++;
    end while (wreq !== 1'b0 && n < 20);
    tmo(n);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic pulse(input int len);
    int n;
    n = 0;
    ext_n <= 1'b0;
    repeat (len) @(posedge clk_i);
    ext_n <= 1'b1;
    // skip the synchroniser lag, in which the old enable still shows
    repeat (3) @(posedge clk_i);
    do begin
      @(posedge clk_i);
      n++;
    end while (spd_oe !== 1'b1 && n < 20);
    tmo(n);
    @(posedge clk_i);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    bus(0, 4'hc, 32'h0, 4'hf);
    chk(q, 32'h0);
    chk({31'h0, spd_oe}, 32'h0);
    q[0] = xo;
    @(posedge clk_i);
    chk({31'h0, xo ^ q[0]}, 32'h1);
    for (int i = 0; i < 16; i++) begin
      {f1, f0, lo, hi} <= 4'(i);
      pulse(25);
      bus(0, `STATUS_OFS, 32'h0, 4'hf);
      e = {13'h0, 2'b11, 1'b0, 1'b1, f0, hi, 1'b1,
           (4'h1 << {f1, f0}) - 4'h1, 1'b0, f1, f0, f0, hi, lo, lo, hi};
      chk(q, e);
      for (int c = 0; c < 8; c++) begin
        bus(1, `CTRL_OFS, 32'(c), 4'hf);
        bus(0, `IND_OFS, 32'h0, 4'hf);
        e = {29'h0, 1'b1, (c[1] & ~c[2]) ^ f0, c[0] ^ hi};
        chk(q, e);
        chk({29'h0, act_oe, act_o, spd_o}, e);
      end
    end
    ext_n <= 1'b0;
    repeat (10) @(posedge clk_i);
    bus(1, `CTRL_OFS, 32'h7, 4'hf);
    bus(0, `CTRL_OFS, 32'h0, 4'hf);
    chk(q, 32'h0);
    chk({31'h0, spd_oe}, 32'h0);
    pulse(1);
    pulse(10);
    bus(0, `STATUS_OFS, 32'h0, 4'hf);
    chk({31'h0, q[16]}, 32'h1);
    bus(1, `STATUS_OFS, 32'h10000, 4'h4);
    bus(0, `STATUS_OFS, 32'h0, 4'hf);
    chk({31'h0, q[16]}, 32'h0);
    wrap_up();
  end
endmodule

// [rtl/hub_strap_top.sv]
// Behaviour
// - speed indicator polarity follows latched high select
// - speed indicator asserted at high speed only
// - latch high select at reset release edge
// - low reset pin forces reset state
// - activity negated when unconfigured or suspended
// - activity asserted only when configured and active
// - self-power strap low means bus powered
// - reference timing from 24 MHz oscillator input; the code only checks that the input toggles and times on clk_i
// - latch two fixed-port strap bits at release
// - activity polarity follows fixed-port strap lsb
// - latch low select, combine into config method
//
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/10ps
`include "hub_strap_map.svh"
module hub_strap_top
  import hub_strap_pkg::*;
#(
  parameter int unsigned REF_WIN = `REF_WIN_CYC
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ext_reset_n_i,
  input wire logic upstream_speed_indicator_i,
  output logic upstream_speed_indicator_o,
  output logic upstream_speed_indicator_oe_o,
  input wire logic activity_indicator_i,
  output logic activity_indicator_o,
  output logic activity_indicator_oe_o,
  input wire logic config_method_select_lo_i,
  input wire logic fixed_port_strap_msb_i,
  input wire logic ref_osc_in_i,
  output logic ref_osc_out_o,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);

  localparam int unsigned RST_MIN = `RESET_MIN_CYC;
  localparam int unsigned CNT_W = $clog2(RST_MIN + 1);
  localparam int unsigned WIN_W = $clog2(REF_WIN + 1);

  logic [`SY_W-1:0] sync1_q;
  logic [`SY_W-1:0] sync2_q;
  logic rst_n_prev_q;
  logic ref_prev_q;
  logic rst_rise;
  logic ref_edge;
  logic ctrl_wr;
  logic short_clr;
  rst_state_t state_q;
  rst_state_t state_d;
  logic [CNT_W-1:0] low_cnt_q;
  logic short_rst_q;
  logic [WIN_W-1:0] win_cnt_q;
  logic ref_seen_q;
  logic ref_active_q;
  logic [`CTRL_W-1:0] ctrl_q;
  logic ack_q;
  logic req;
  logic wr_take;
  logic spd_assert;
  logic act_assert;
  logic act_low;
  logic drive_q;
  logic [31:0] status_w;
  logic [31:0] ind_w;

  strap_if st ();

  // two-flop synchronisers for every pin-sourced input
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sync1_q <= `SY_IDLE;
      sync2_q <= `SY_IDLE;
    end else begin
      sync1_q <= {ref_osc_in_i, fixed_port_strap_msb_i,
                  config_method_select_lo_i, activity_indicator_i,
                  upstream_speed_indicator_i, ext_reset_n_i};
      sync2_q <= sync1_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rst_n_prev_q <= 1'b1;
      ref_prev_q <= 1'b0;
    end else begin
      rst_n_prev_q <= sync2_q[`SY_RST_N];
      ref_prev_q <= sync2_q[`SY_REF];
    end
  end

  assign rst_rise = sync2_q[`SY_RST_N] & ~rst_n_prev_q;

  // any level change on the synchronised oscillator input
  assign ref_edge = sync2_q[`SY_REF] ^ ref_prev_q;

  // pin reset sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_HELD: if (rst_rise) state_d = ST_LATCH;
      ST_LATCH: state_d = ST_RUN;
      ST_RUN: state_d = ST_RUN;
      default: state_d = ST_HELD;
    endcase
    if (!sync2_q[`SY_RST_N]) begin
      state_d = ST_HELD;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= ST_HELD;
    end else begin
      state_q <= state_d;
    end
  end

  // measures how long the reset pin stayed low
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      low_cnt_q <= '0;
    end else if (!sync2_q[`SY_RST_N]) begin
      if (low_cnt_q != CNT_W'(RST_MIN)) begin
        low_cnt_q <= low_cnt_q + CNT_W'(1);
      end
    end else if (rst_rise) begin
      low_cnt_q <= '0;
    end
  end

  // sticky flag for a pulse shorter than the system must give
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      short_rst_q <= 1'b0;
    end else if (rst_rise && low_cnt_q < CNT_W'(RST_MIN)) begin
      short_rst_q <= 1'b1;
    end else if (short_clr && avs_writedata_i[`ST_SHORT_RST_BIT]) begin
      short_rst_q <= 1'b0;
    end
  end

  // straps are read from the shared pins while the pins are inputs
  assign st.pin_cfg_hi = sync2_q[`SY_SPD];
  assign st.pin_cfg_lo = sync2_q[`SY_CFG_LO];
  assign st.pin_shared = sync2_q[`SY_ACT];
  assign st.pin_fix_msb = sync2_q[`SY_FIX_MSB];
  assign st.latch = rst_rise;
  assign st.hold = ~sync2_q[`SY_RST_N];

  strap_sampler u_sampler (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .st(st.sampler)
  );

  // 20 MHz sampling aliases 24 MHz; this only proves the input toggles
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      win_cnt_q <= '0;
      ref_seen_q <= 1'b0;
      ref_active_q <= 1'b0;
    end else if (win_cnt_q == WIN_W'(REF_WIN - 1)) begin
      win_cnt_q <= '0;
      ref_seen_q <= 1'b0;
      ref_active_q <= ref_seen_q | ref_edge;
    end else begin
      win_cnt_q <= win_cnt_q + WIN_W'(1);
      if (ref_edge) begin
        ref_seen_q <= 1'b1;
      end
    end
  end

  // crystal feedback leg
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ref_osc_out_o <= 1'b0;
    end else begin
      ref_osc_out_o <= ~sync2_q[`SY_REF];
    end
  end

  // hub state inputs written by software
  always_ff @(posedge clk_i) begin
    if (reset_i || state_q == ST_HELD) begin
      ctrl_q <= `CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= avs_writedata_i[`CTRL_W-1:0];
    end
  end

  assign spd_assert = ctrl_q[`CTRL_HS_BIT];
  assign act_assert = ctrl_q[`CTRL_CFGD_BIT] &
                      ~ctrl_q[`CTRL_SUSP_BIT];
  assign act_low = st.fixed_code[0];

  // indicators drive only once straps are latched
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      drive_q <= 1'b0;
    end else begin
      drive_q <= state_d == ST_RUN && st.valid;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || state_d != ST_RUN) begin
      upstream_speed_indicator_o <= 1'b0;
      activity_indicator_o <= 1'b0;
    end else begin
      upstream_speed_indicator_o <= spd_assert ^ st.cfg_hi;
      activity_indicator_o <= act_assert ^ act_low;
    end
  end

  assign upstream_speed_indicator_oe_o = drive_q;
  assign activity_indicator_oe_o = drive_q;

  // register bus: one wait cycle per access
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr_take = avs_write_i & ack_q;

  // one register's write strobe, on the taking edge and its byte lane
  function automatic logic reg_wr(input logic take,
                                  input logic [3:0] addr,
                                  input logic [3:0] ofs,
                                  input logic lane_en);
    reg_wr = take && addr == ofs && lane_en;
  endfunction

  assign ctrl_wr = reg_wr(wr_take, avs_address_i, `CTRL_OFS,
                          avs_byteenable_i[0]);
  assign short_clr = reg_wr(wr_take, avs_address_i, `STATUS_OFS,
                            avs_byteenable_i[`ST_SHORT_RST_BIT/8]);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_comb begin
    status_w = '0;
    status_w[`ST_CFG_HI_BIT] = st.cfg_hi;
    status_w[`ST_CFG_LO_BIT] = st.method[0];
    status_w[`ST_METHOD_LSB +: 2] = st.method;
    status_w[`ST_SELF_PWR_BIT] = st.power_src;
    status_w[`ST_FIX_LSB +: 2] = st.fixed_code;
    status_w[`ST_MASK_LSB +: 4] = fixed_port_mask(st.fixed_code);
    status_w[`ST_VALID_BIT] = st.valid;
    status_w[`ST_SPD_LOW_BIT] = st.cfg_hi;
    status_w[`ST_ACT_LOW_BIT] = act_low;
    status_w[`ST_REF_ACT_BIT] = ref_active_q;
    status_w[`ST_SHORT_RST_BIT] = short_rst_q;
    status_w[`ST_FSM_LSB +: 2] = state_q;
  end

  always_comb begin
    ind_w = '0;
    ind_w[`IND_SPD_BIT] = upstream_speed_indicator_o;
    ind_w[`IND_ACT_BIT] = activity_indicator_o;
    ind_w[`IND_OE_BIT] = drive_q;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      avs_readdata_o <= '0;
    end else if (avs_read_i && !ack_q) begin
      unique case (avs_address_i)
        `CTRL_OFS: avs_readdata_o <= {{(32-`CTRL_W){1'b0}}, ctrl_q};
        `STATUS_OFS: avs_readdata_o <= status_w;
        `IND_OFS: avs_readdata_o <= ind_w;
        default: avs_readdata_o <= '0;
      endcase
    end
  end

endmodule

// [rtl/strap_sampler.sv]
`timescale 1ns/10ps
module strap_sampler
  import hub_strap_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  strap_if.sampler st
);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st.cfg_hi <= 1'b0;
      st.method <= CFG_METHOD_0;
      st.power_src <= PWR_BUS_ONLY;
      st.fixed_code <= FIX_NONE;
    end else if (st.latch) begin
      st.cfg_hi <= st.pin_cfg_hi;
      st.method <= cfg_method_t'({st.pin_cfg_hi, st.pin_cfg_lo});
      st.power_src <= power_src_t'(st.pin_shared);
      st.fixed_code <= fixed_code_t'({st.pin_fix_msb, st.pin_shared});
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i || st.hold) begin
      st.valid <= 1'b0;
    end else if (st.latch) begin
      st.valid <= 1'b1;
    end
  end

endmodule
